// ===== src/pdc_counter_chain.sv
// Divider counter chain: prescaler, swallow, main and reference counters, PFD.
// Assumes RF and reference inputs are far slower than clk_i (40 MHz) and
// that the programming word is quasi-static, coming from pins or a loader.
`include "pdc_consts.svh"
module pdc_counter_chain
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      resetn_i,
  // Divider inputs
  input  wire logic      rf_in_i,
  input  wire logic      ref_in_i,
  // Programming
  input  wire logic      direct_mode_i,
  input  wire pdc_word_t prog_word_i,
  input  wire pdc_word_t direct_word_i,
  // Divided outputs and detector
  output logic           main_div_o,
  output logic           ref_div_o,
  output logic           modulus_select_out_o,
  output logic           pfd_up_o,
  output logic           pfd_down_o,
  output logic           prescaler_active_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Rising edge once the second and third stages agree high
  function automatic logic rise_f(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) && s[2] && !lvl;
  endfunction

  // Filtered level follows only agreeing stages
  function automatic logic level_f(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // --------------------------------------------------------------------------
  // Input synchronisers and configuration
  // --------------------------------------------------------------------------
  logic [20:0] sel_cfg;
  logic [20:0] cfg_s0_reg, cfg_s1_reg, cfg_s2_reg, cfg_reg, cfg_next;
  logic [2:0]  rf_sync_reg, ref_sync_reg;
  logic        rf_lvl_reg, rf_lvl_next, ref_lvl_reg, ref_lvl_next;
  logic        rf_rise, ref_rise;

  // Source select; direct pins leave the top four word bits low
  always_comb begin
    if (direct_mode_i) begin
      sel_cfg = {1'b1, 4'h0, direct_word_i[`PDC_DIRECT_W-1:0]};
    end else begin
      sel_cfg = {1'b0, prog_word_i};
    end
    cfg_next     = (cfg_s1_reg == cfg_s2_reg) ? cfg_s2_reg : cfg_reg;
    rf_lvl_next  = level_f(rf_sync_reg, rf_lvl_reg);
    ref_lvl_next = level_f(ref_sync_reg, ref_lvl_reg);
    rf_rise      = rise_f(rf_sync_reg, rf_lvl_reg);
    ref_rise     = rise_f(ref_sync_reg, ref_lvl_reg);
  end

  // Three stages per pin; a mismatch holds the old settled value
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s0_reg   <= `PDC_CFG_RST;
      cfg_s1_reg   <= `PDC_CFG_RST;
      cfg_s2_reg   <= `PDC_CFG_RST;
      cfg_reg      <= `PDC_CFG_RST;
      rf_sync_reg  <= 3'h0;
      ref_sync_reg <= 3'h0;
      rf_lvl_reg   <= 1'b0;
      ref_lvl_reg  <= 1'b0;
    end else begin
      cfg_s0_reg   <= sel_cfg;
      cfg_s1_reg   <= cfg_s0_reg;
      cfg_s2_reg   <= cfg_s1_reg;
      cfg_reg      <= cfg_next;
      rf_sync_reg  <= {rf_sync_reg[1:0], rf_in_i};
      ref_sync_reg <= {ref_sync_reg[1:0], ref_in_i};
      rf_lvl_reg   <= rf_lvl_next;
      ref_lvl_reg  <= ref_lvl_next;
    end
  end

  // Field decode of the settled word
  logic      main_count_bit_seven, main_count_bit_eight;
  logic      ref_count_bit_four, ref_count_bit_five;
  logic      bypass;
  pdc_main_t m_val;
  pdc_ref_t  r_val;
  pdc_swal_t a_val;

  assign main_count_bit_seven = cfg_reg[`PDC_MAIN_B7_POS];
  assign main_count_bit_eight = cfg_reg[`PDC_MAIN_B8_POS];
  assign ref_count_bit_four   = cfg_reg[`PDC_REF_HI_POS];
  assign ref_count_bit_five   = cfg_reg[`PDC_REF_HI_POS+1];
  assign bypass = cfg_reg[`PDC_PRE_EN_N_POS];
  assign m_val  = {main_count_bit_eight, main_count_bit_seven,
                   cfg_reg[`PDC_MAIN_LO_POS +: `PDC_MAIN_LO_W]};
  assign r_val  = {ref_count_bit_five, ref_count_bit_four,
                   cfg_reg[`PDC_REF_LO_POS +: `PDC_REF_LO_W]};
  assign a_val  = cfg_reg[`PDC_SWAL_POS +: `PDC_SWAL_W];

  // --------------------------------------------------------------------------
  // Main chain: prescaler, swallow and main counter
  // --------------------------------------------------------------------------
  pdc_pre_t  pre_cnt_reg, pre_cnt_next, pre_term;
  pdc_swal_t a_left_reg, a_left_next;
  pdc_main_t m_cnt_reg, m_cnt_next;
  pdc_mod_e  mod_sel, mod_sel_reg;
  logic      main_tick, main_pulse_reg, main_pulse_next, active_reg;

  // Modulus 11 while swallow cycles remain in this main period
  always_comb begin
    mod_sel  = (!bypass && a_left_reg != '0) ? PDC_MOD_HIGH : PDC_MOD_LOW;
    pre_term = (mod_sel == PDC_MOD_HIGH) ? pdc_pre_t'(`PDC_PRE_HIGH_DIV - 1)
                                         : pdc_pre_t'(`PDC_PRE_LOW_DIV - 1);
    pre_cnt_next    = pre_cnt_reg;
    a_left_next     = a_left_reg;
    m_cnt_next      = m_cnt_reg;
    main_tick       = 1'b0;
    main_pulse_next = 1'b0;
    if (bypass) begin
      // Prescaler held idle; RF edges clock the main counter
      pre_cnt_next = '0;
      a_left_next  = '0;
      main_tick    = rf_rise;
    end else if (rf_rise) begin
      // RF through the prescaler
      if (pre_cnt_reg >= pre_term) begin
        pre_cnt_next = '0;
        main_tick    = 1'b1;
        if (a_left_reg != '0) begin
          a_left_next = a_left_reg - 1'b1;
        end
      end else begin
        pre_cnt_next = pre_cnt_reg + 1'b1;
      end
    end
    // Down count from M: M+1 ticks per period, so M=1 gives 2
    if (main_tick) begin
      if (m_cnt_reg == '0) begin
        m_cnt_next      = m_val;
        main_pulse_next = 1'b1;
        a_left_next     = bypass ? pdc_swal_t'(0) : a_val;
      end else begin
        m_cnt_next = m_cnt_reg - 1'b1;
      end
    end
  end

  // Main chain state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg    <= '0;
      a_left_reg     <= '0;
      m_cnt_reg      <= '0;
      main_pulse_reg <= 1'b0;
      mod_sel_reg    <= PDC_MOD_LOW;
      active_reg     <= 1'b0;
    end else begin
      pre_cnt_reg    <= pre_cnt_next;
      a_left_reg     <= a_left_next;
      m_cnt_reg      <= m_cnt_next;
      main_pulse_reg <= main_pulse_next;
      mod_sel_reg    <= mod_sel;
      active_reg     <= !bypass;
    end
  end

  // --------------------------------------------------------------------------
  // Reference counter
  // --------------------------------------------------------------------------
  pdc_ref_t r_cnt_reg, r_cnt_next;
  logic     ref_pulse_reg, ref_pulse_next;

  // R=0 reloads zero each edge, so every edge passes
  always_comb begin
    r_cnt_next     = r_cnt_reg;
    ref_pulse_next = 1'b0;
    if (ref_rise) begin
      if (r_cnt_reg == '0) begin
        r_cnt_next     = r_val;
        ref_pulse_next = 1'b1;
      end else begin
        r_cnt_next = r_cnt_reg - 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Phase-frequency detector
  // --------------------------------------------------------------------------
  logic up_reg, up_next, down_reg, down_next;

  // Two-flag detector; both set means aligned, so both clear at once
  always_comb begin
    up_next   = up_reg || ref_pulse_reg;
    down_next = down_reg || main_pulse_reg;
    if (up_next && down_next) begin
      up_next   = 1'b0;
      down_next = 1'b0;
    end
  end

  // Reference and detector state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_cnt_reg     <= '0;
      ref_pulse_reg <= 1'b0;
      up_reg        <= 1'b0;
      down_reg      <= 1'b0;
    end else begin
      r_cnt_reg     <= r_cnt_next;
      ref_pulse_reg <= ref_pulse_next;
      up_reg        <= up_next;
      down_reg      <= down_next;
    end
  end

  // Outputs straight from flops
  assign main_div_o           = main_pulse_reg;
  assign ref_div_o            = ref_pulse_reg;
  assign modulus_select_out_o = mod_sel_reg;
  assign pfd_up_o             = up_reg;
  assign pfd_down_o           = down_reg;
  assign prescaler_active_o   = active_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  pre_wrap_a: assert property (!bypass && rf_rise && pre_cnt_reg == pre_term |=>
    pre_cnt_reg == 4'h0) else $error("prescaler did not wrap at its modulus");
  pre_high_a: assert property (a_left_reg != 4'h0 && !bypass |-> pre_term == 4'hA)
    else $error("swallow cycle not at divide by 11");
  main_reload_a: assert property (main_tick && m_cnt_reg == 9'h000 |=>
    m_cnt_reg == $past(m_val) && main_div_o) else $error("main counter reload wrong");
  swallow_load_a: assert property (main_tick && m_cnt_reg == 9'h000 && !bypass |=>
    a_left_reg == $past(a_val)) else $error("swallow count not reloaded");
  bypass_idle_a: assert property (bypass |=> pre_cnt_reg == 4'h0 && a_left_reg == 4'h0
    && !modulus_select_out_o) else $error("prescaler active in bypass");
  bypass_tick_a: assert property (bypass && rf_rise && m_cnt_reg == 9'h000 &&
    $stable(cfg_reg) |=> main_div_o) else $error("bypass edge lost");
  ref_pass_a: assert property (r_val == 6'h00 && r_cnt_reg == 6'h00 && ref_rise |=>
    ref_div_o ##1 !ref_div_o) else $error("reference pass-through wrong");
  ref_count_a: assert property (ref_rise && r_cnt_reg != 6'h00 |=>
    r_cnt_reg == $past(r_cnt_reg) - 6'h01 && !ref_div_o) else $error("reference count wrong");
  direct_force_a: assert property (cfg_reg[20] |-> m_val[8:7] == 2'h0 &&
    r_val[5:4] == 2'h0) else $error("direct mode top bits not forced");
  pfd_excl_a: assert property (!(pfd_up_o && pfd_down_o))
    else $error("up and down both high");
  pfd_up_a: assert property (ref_div_o && !main_div_o && !pfd_down_o |=> pfd_up_o)
    else $error("up not raised on reference pulse");

  main_pulse_c: cover property (main_div_o && prescaler_active_o);
  bypass_pulse_c: cover property (main_div_o && !prescaler_active_o);
  swallow_c: cover property (modulus_select_out_o ##[1:200] !modulus_select_out_o);
  pfd_up_c: cover property (pfd_up_o ##1 !pfd_up_o);

endmodule

// ===== shared/pdc_consts.svh
// Constants of the divider counter chain: programming word layout and moduli.
// Assumes the guard below keeps a second inclusion (package, design) harmless.
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PDC_WORD_W        20
`define PDC_MAIN_W        9
`define PDC_REF_W         6
`define PDC_SWAL_W        4
`define PDC_PRE_W         4
`define PDC_SYNC_STAGES   3

// ----------------------------------------------------------------------------
// Programming word fields (bit positions)
// ----------------------------------------------------------------------------
`define PDC_REF_HI_POS    18
`define PDC_MAIN_B7_POS   16
`define PDC_MAIN_B8_POS   17
`define PDC_PRE_EN_N_POS  15
`define PDC_MAIN_LO_POS   8
`define PDC_MAIN_LO_W     7
`define PDC_REF_LO_POS    4
`define PDC_REF_LO_W      4
`define PDC_SWAL_POS      0
`define PDC_DIRECT_W      16

// ----------------------------------------------------------------------------
// Prescaler moduli and reset values
// ----------------------------------------------------------------------------
`define PDC_PRE_LOW_DIV   10
`define PDC_PRE_HIGH_DIV  11
`define PDC_CFG_RST       21'h08000

`endif

// ===== shared/pdc_pkg.sv
// Types shared by the divider counter chain.
// Assumes pdc_consts.svh is on the include path.
package pdc_pkg;
  `include "pdc_consts.svh"

  typedef logic [`PDC_WORD_W-1:0] pdc_word_t;
  typedef logic [`PDC_MAIN_W-1:0] pdc_main_t;
  typedef logic [`PDC_REF_W-1:0]  pdc_ref_t;
  typedef logic [`PDC_SWAL_W-1:0] pdc_swal_t;
  typedef logic [`PDC_PRE_W-1:0]  pdc_pre_t;

  // Prescaler modulus as seen on the modulus select output
  typedef enum logic {
    PDC_MOD_LOW  = 1'b0,
    PDC_MOD_HIGH = 1'b1
  } pdc_mod_e;
endpackage

// ===== verification/pdc_osc_model.sv
// Far-side model: free-running RF (VCO) and reference oscillators.
// Assumes the bench clock drives clk_i; edges move 1 ns after its rise.
module pdc_osc_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] rf_half_i,
  input  wire logic [7:0] ref_half_i,
  // Oscillator outputs
  output logic            rf_o,
  output logic            ref_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rf_cnt  = 8'h00;
  logic [7:0] ref_cnt = 8'h00;

  // Half periods in bench clocks; kept >= 3 so the chain loses no edge
  initial begin
    rf_o  = 1'b0;
    ref_o = 1'b0;
  end
  always @(posedge clk_i) begin
    #1;
    if (run_i) begin
      rf_cnt  = rf_cnt + 8'h01;
      ref_cnt = ref_cnt + 8'h01;
      if (rf_cnt >= rf_half_i) begin
        rf_o   = ~rf_o;
        rf_cnt = 8'h00;
      end
      if (ref_cnt >= ref_half_i) begin
        ref_o   = ~ref_o;
        ref_cnt = 8'h00;
      end
    end
  end
endmodule

// ===== verification/pdc_counter_chain_bench.sv
// Self-checking bench for the divider counter chain.
// Assumes the package and the oscillator model are compiled before it.
module pdc_counter_chain_bench import pdc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, resetn_i, direct_mode_i, run, rf_in_i, ref_in_i;
  pdc_word_t   prog_word_i, direct_word_i;
  logic        main_div_o, ref_div_o, modulus_select_out_o;
  logic        pfd_up_o, pfd_down_o, prescaler_active_o;
  logic [7:0]  rf_half, ref_half;
  logic [31:0] main_q[$];
  logic [15:0] ref_q[$];
  logic [15:0] rf_n = 16'h0000, hi_n = 16'h0000, rr_n = 16'h0000;
  logic        rf_d = 1'b0, rr_d = 1'b0;
  int          fails = 0, tests_run = 0, m, a, r;

  // ---------------------------------------------------------------------
  // Clock, design and far side
  // ---------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  pdc_counter_chain pdc_counter_chain_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .rf_in_i(rf_in_i), .ref_in_i(ref_in_i), .direct_mode_i(direct_mode_i),
    .prog_word_i(prog_word_i), .direct_word_i(direct_word_i), .main_div_o(main_div_o),
    .ref_div_o(ref_div_o), .modulus_select_out_o(modulus_select_out_o),
    .pfd_up_o(pfd_up_o), .pfd_down_o(pfd_down_o), .prescaler_active_o(prescaler_active_o));
  pdc_osc_model pdc_osc_model_i (.clk_i(clk_i), .run_i(run), .rf_half_i(rf_half),
    .ref_half_i(ref_half), .rf_o(rf_in_i), .ref_o(ref_in_i));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic pdc_word_t mk(input logic [5:0] rv, input logic [8:0] mv,
                                   input logic byp, input logic [3:0] av);
    return {rv[5:4], mv[8], mv[7], byp, mv[6:0], rv[3:0], av};
  endfunction
  // Packed note: prescaler active, edges at divide-by-11, edges per period
  function automatic logic [31:0] mexp(input int mv, input int av, input logic byp);
    if (byp) return {1'b0, 15'h0000, 16'(mv + 1)};
    return {1'b1, 15'(11 * av), 16'(10 * (mv + 1) + av)};
  endfunction
  task automatic do_reset();
    @(posedge clk_i);
    #1 resetn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    check({main_div_o, ref_div_o, modulus_select_out_o, pfd_up_o, pfd_down_o,
           prescaler_active_o}, 32'h0000_0000, "outputs in reset");
    #1 resetn_i = 1'b1;
  endtask
  // Apply a word, let two periods flush, then note three expected periods
  task automatic run_cfg(input logic mode, input pdc_word_t w, input logic [31:0] me,
                         input logic [15:0] re);
    @(posedge clk_i);
    #1 direct_mode_i = mode;
    if (mode) direct_word_i = w;
    else prog_word_i = w;
    fork
      begin
        repeat (2) @(negedge clk_i iff main_div_o === 1'b1);
        @(posedge clk_i);
        repeat (3) main_q.push_back(me);
      end
      begin
        repeat (2) @(negedge clk_i iff ref_div_o === 1'b1);
        @(posedge clk_i);
        repeat (3) ref_q.push_back(re);
      end
    join
    while (main_q.size() + ref_q.size() > 0) @(posedge clk_i);
  endtask
  task automatic pfd_window(input logic up_wins);
    int u, d;
    u = 0;
    d = 0;
    repeat (600) begin
      @(negedge clk_i);
      if (pfd_up_o === 1'b1) u++;
      if (pfd_down_o === 1'b1) d++;
    end
    check(32'({u > d, u + d > 0}), 32'({up_wins, 1'b1}), "detector balance");
  endtask

  // ---------------------------------------------------------------------
  // Watchers: edges between pulses, compared against the oldest note
  // ---------------------------------------------------------------------
  always @(negedge clk_i) begin
    if (rf_in_i && !rf_d) begin
      rf_n = rf_n + 16'h0001;
      if (modulus_select_out_o === PDC_MOD_HIGH) hi_n = hi_n + 16'h0001;
    end
    rf_d = rf_in_i;
    if (ref_in_i && !rr_d) rr_n = rr_n + 16'h0001;
    rr_d = ref_in_i;
    if (main_div_o === 1'b1) begin
      if (main_q.size() > 0) check({prescaler_active_o, hi_n[14:0], rf_n},
        main_q.pop_front(), "main period");
      rf_n = 16'h0000;
      hi_n = 16'h0000;
    end
    if (ref_div_o === 1'b1) begin
      if (ref_q.size() > 0) check(rr_n, ref_q.pop_front(), "ref period");
      rr_n = 16'h0000;
    end
  end

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    run = 1'b0;
    direct_mode_i = 1'b0;
    prog_word_i = mk(6'h00, 9'h001, 1'b1, 4'h0);
    direct_word_i = '0;
    rf_half = 8'h04;
    ref_half = 8'h05;
    void'($urandom(32'h044F));
    do_reset();
    run = 1'b1;
    // Bypass, smallest main value, swallow ignored, reference passed through
    run_cfg(1'b0, mk(6'h00, 9'h001, 1'b1, 4'h5), mexp(1, 0, 1'b1), 16'h0001);
    // Main count bit seven and largest reference value
    run_cfg(1'b0, mk(6'h3F, 9'h081, 1'b1, 4'h0), mexp(129, 0, 1'b1), 16'h0040);
    do_reset();
    // Prescaler on, swallow up to its ceiling of main plus one
    for (a = 0; a <= 2; a++) begin
      run_cfg(1'b0, mk(6'h02, 9'h001, 1'b0, 4'(a)), mexp(1, a, 1'b0), 16'h0003);
    end
    repeat (3) begin
      m = 2 + $urandom % 4;
      a = $urandom % (m + 2);
      r = $urandom % 16;
      run_cfg(1'b0, mk(6'(r), 9'(m), 1'b0, 4'(a)), mexp(m, a, 1'b0), 16'(r + 1));
    end
    // Pins with main bit seven set, and main bit eight and top reference bits in the first; those must read as zero
    run_cfg(1'b1, mk(6'h32, 9'h183, 1'b1, 4'h7), mexp(3, 0, 1'b1), 16'h0003);
    run_cfg(1'b1, mk(6'h00, 9'h082, 1'b0, 4'h3), mexp(2, 3, 1'b0), 16'h0001);
    // Reference far faster than divided RF, then the reverse
    run_cfg(1'b0, mk(6'h00, 9'h007, 1'b1, 4'h0), mexp(7, 0, 1'b1), 16'h0001);
    pfd_window(1'b1);
    run_cfg(1'b0, mk(6'h0F, 9'h001, 1'b1, 4'h0), mexp(1, 0, 1'b1), 16'h0010);
    pfd_window(1'b0);
    final_report();
  end

  // Watchdog well beyond the expected run of about 15000 cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
